/* File: core/scs_pkg.sv */
// shared constants for the serial control/status upper-bit block
package scs_pkg;
  localparam int WORD_W = 24;
  localparam logic [4:0] FRAME_BITS = 5'h18;
  localparam logic [4:0] COUNT_OVER = 5'h19;
  // input register (write) bit positions
  localparam int BIT_SELECT = 0;
  localparam int BIT_DRV_LO = 1;
  localparam int BIT_DRV_HI = 17;
  localparam int BIT_CM_LO = 18;
  localparam int BIT_CM_HI = 19;
  localparam int BIT_REC_DIS = 20;
  localparam int BIT_OC_DUTY = 21;
  localparam int BIT_STATUS_CLR = 22;
  localparam int BIT_ENABLE = 23;
  // status register (read) bit positions
  localparam int ST_FAULT = 0;
  localparam int ST_NOT_READY = 18;
  localparam int ST_WARN = 19;
  localparam int ST_THERMAL = 20;
  localparam int ST_UNDERVOLT = 21;
  localparam int ST_OVERVOLT = 22;
  localparam int ST_ALWAYS_ONE = 23;
  // reset values
  localparam logic [23:0] CTRL_RESET = 24'h000000;
  localparam logic [16:0] DRV_OFF = 17'h00000;
  // current monitor codes, bit 19 high, bit 18 low
  localparam logic [1:0] CM_OUTPUT_EIGHT = 2'h0;
  localparam logic [1:0] CM_OUTPUT_ONE = 2'h1;
  localparam logic [1:0] CM_OUTPUT_FIVE = 2'h2;
  localparam logic [1:0] CM_OUTPUT_FOUR = 2'h3;
  // retry duty in percent for duty select 0 and 1
  localparam int OC_DUTY_LOW_PCT = 12;
  localparam int OC_DUTY_HIGH_PCT = 25;
  // timing
  localparam int CLK_PERIOD_NS = 20;
  localparam int STARTUP_TIME_NS = 200000;
  localparam int STARTUP_CYCLES = (STARTUP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SYNC_STAGES = 3;
  // synchronised input positions
  localparam int IN_SCK = 0;
  localparam int IN_CS = 1;
  localparam int IN_DI = 2;
  localparam int IN_OV = 3;
  localparam int IN_UV = 4;
  localparam int IN_TSD = 5;
  localparam int IN_TW = 6;
  localparam int IN_W = 7;
  localparam logic [6:0] IN_INIT = 7'h02;
  typedef enum logic [0:0] {
    SCS_IDLE  = 1'b0,
    SCS_FRAME = 1'b1
  } scs_frame_t;
endpackage

/* File: core/scs_sync.sv */
// three-stage input synchroniser with agreement filter
module scs_sync #(
  parameter int          W      = 1,
  parameter logic [63:0] P_INIT = 64'h0
) (
  input  wire logic         i_sys_clk,
  input  wire logic         i_rst_n,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_level
);
  import scs_pkg::*;

  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      logic s1;
      logic s2;
      logic s3;
      always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          s1 <= P_INIT[g];
          s2 <= P_INIT[g];
          s3 <= P_INIT[g];
        end else begin
          s1 <= i_async[g];
          s2 <= s1;
          s3 <= s2;
        end
      end
      // only accept a level once two late stages agree
      always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          o_level[g] <= P_INIT[g];
        end else if (s2 == s3) begin
          o_level[g] <= s3;
        end
      end
    end
  endgenerate
endmodule

/* File: core/scs_timer.sv */
// start-up settle timer for the charge pump
module scs_timer #(
  parameter int unsigned P_CYCLES = 10
) (
  input  wire logic i_sys_clk,
  input  wire logic i_rst_n,
  input  wire logic i_start,
  input  wire logic i_abort,
  output logic      o_busy
);
  import scs_pkg::*;

  localparam int CW = $clog2(P_CYCLES + 1);
  localparam logic [CW-1:0] LOAD = CW'(P_CYCLES);
  localparam logic [CW-1:0] ONE = CW'(1);

  logic [CW-1:0] count;

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      count  <= '0;
      o_busy <= 1'b0;
    end else if (i_abort) begin
      count  <= '0;
      o_busy <= 1'b0;
    end else if (i_start) begin
      count  <= LOAD;
      o_busy <= 1'b1;
    end else if (o_busy) begin
      count  <= count - ONE;
      o_busy <= (count != ONE);
    end
  end
endmodule

/* File: core/scs_ctrl_status.sv */
// serial-framed control word and status word with supply/thermal protection
// Function
// - status-clear bit clears both status words at frame end
// - duty select bit sets over-current retry duty
// - supply over/undervoltage sets flag, outputs off
// - auto resume only when recovery disable clear
// - top read-back status bit always one for status_a; a word b read returns i_status_word_b[23] there
// - thermal shutdown sets flag, outputs held off
// - temperature warning flag never disables outputs
// - standby to active starts timer, not-ready set
// - not-ready clears itself when timer expires
// - frame writing top bit zero enters standby
// - commit only frames of exactly 24 clocks
// - first bit selects word written and read
module scs_ctrl_status #(
  parameter int unsigned P_STARTUP_CYCLES = scs_pkg::STARTUP_CYCLES
) (
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_serial_clock,
  input  wire logic        i_chip_select_low,
  input  wire logic        i_serial_input_pin,
  input  wire logic        i_load_supply_over,
  input  wire logic        i_load_supply_under,
  input  wire logic        i_thermal_shutdown,
  input  wire logic        i_temperature_warning,
  input  wire logic [16:0] i_overcurrent_flags,
  input  wire logic [23:0] i_status_word_b,
  output logic             o_serial_output,
  output logic             o_serial_output_en,
  output logic             o_standby,
  output logic             o_outputs_enable,
  output logic [16:0]      o_driver_on,
  output logic             o_oc_retry_duty_high,
  output logic [3:0]       o_current_monitor_output,
  output logic             o_status_clear,
  output logic [23:0]      o_word_b,
  output logic             o_word_b_write
);
  import scs_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  logic [IN_W-1:0] sync_in;
  logic            sck;
  logic            cs_low;
  logic            di;
  logic            sck_d;
  logic            cs_d;
  logic            sck_rise;
  logic            sck_fall;
  logic            cs_fall;
  logic            cs_rise;

  scs_sync #(
    .W      (IN_W),
    .P_INIT (64'(IN_INIT))
  ) u_sync (
    .i_sys_clk (i_sys_clk),
    .i_rst_n   (i_rst_n),
    .i_async   ({i_temperature_warning, i_thermal_shutdown, i_load_supply_under,
                 i_load_supply_over, i_serial_input_pin, i_chip_select_low,
                 i_serial_clock}),
    .o_level   (sync_in)
  );

  assign sck    = sync_in[IN_SCK];
  assign cs_low = sync_in[IN_CS];
  assign di     = sync_in[IN_DI];

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sck_d <= 1'b0;
      cs_d  <= 1'b1;
    end else begin
      sck_d <= sck;
      cs_d  <= cs_low;
    end
  end

  assign sck_rise = sck & ~sck_d;
  assign sck_fall = ~sck & sck_d;
  assign cs_fall  = ~cs_low & cs_d;
  assign cs_rise  = cs_low & ~cs_d;

  ////////////////////////////////////////////////////////////////////////////
  scs_frame_t  state;
  logic [4:0]  bit_cnt;
  logic [23:0] in_sr;
  logic [23:0] out_sr;
  logic        frame_ok;
  logic        wr_a;
  logic        wr_b;
  logic        status_clr;
  logic        go_standby;

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state   <= SCS_IDLE;
      bit_cnt <= 5'h00;
      in_sr   <= CTRL_RESET;
    end else begin
      case (state)
        SCS_IDLE: begin
          if (cs_fall) begin
            state   <= SCS_FRAME;
            bit_cnt <= 5'h00;
          end
        end
        SCS_FRAME: begin
          if (cs_rise) begin
            state <= SCS_IDLE;
          end else if (sck_rise) begin
            // lsb first: the first bit ends up in bit 0
            in_sr <= {di, in_sr[23:1]};
            if (bit_cnt != COUNT_OVER) begin
              bit_cnt <= bit_cnt + 5'h01;
            end
          end
        end
        default: state <= SCS_IDLE;
      endcase
    end
  end

  // a frame longer or shorter than 24 clocks is dropped whole
  assign frame_ok   = (state == SCS_FRAME) && cs_rise && (bit_cnt == FRAME_BITS);
  assign wr_a       = frame_ok && !in_sr[BIT_SELECT];
  assign wr_b       = frame_ok && in_sr[BIT_SELECT];
  assign go_standby = wr_a && !in_sr[BIT_ENABLE];
  // standby clears everything, status included
  assign status_clr = wr_a && (in_sr[BIT_STATUS_CLR] || !in_sr[BIT_ENABLE]);

  ////////////////////////////////////////////////////////////////////////////
  logic [23:0] ctrl_word;
  logic        enable;
  logic        enable_d;
  logic        not_ready;

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ctrl_word <= CTRL_RESET;
    end else if (go_standby) begin
      ctrl_word <= CTRL_RESET;
    end else if (wr_a) begin
      // the clear bit is an action, never stored
      ctrl_word <= in_sr & ~(24'h000001 << BIT_STATUS_CLR);
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_word_b       <= CTRL_RESET;
      o_word_b_write <= 1'b0;
      o_status_clear <= 1'b0;
    end else begin
      o_word_b_write <= wr_b || go_standby;
      o_status_clear <= status_clr;
      if (go_standby) begin
        o_word_b <= CTRL_RESET;
      end else if (wr_b) begin
        o_word_b <= in_sr;
      end
    end
  end

  assign enable = ctrl_word[BIT_ENABLE];

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      enable_d <= 1'b0;
    end else begin
      enable_d <= enable;
    end
  end

  scs_timer #(
    .P_CYCLES (P_STARTUP_CYCLES)
  ) u_timer (
    .i_sys_clk (i_sys_clk),
    .i_rst_n   (i_rst_n),
    .i_start   (enable && !enable_d),
    .i_abort   (!enable),
    .o_busy    (not_ready)
  );

  ////////////////////////////////////////////////////////////////////////////
  logic ov_flag;
  logic uv_flag;
  logic tsd_flag;
  logic tw_flag;
  logic supply_block;
  logic outputs_ok;

  // a new event in the clearing cycle survives the clear
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ov_flag  <= 1'b0;
      uv_flag  <= 1'b0;
      tsd_flag <= 1'b0;
      tw_flag  <= 1'b0;
    end else begin
      ov_flag  <= sync_in[IN_OV] || (ov_flag && !status_clr);
      uv_flag  <= sync_in[IN_UV] || (uv_flag && !status_clr);
      tsd_flag <= sync_in[IN_TSD] || (tsd_flag && !status_clr);
      tw_flag  <= sync_in[IN_TW] || (tw_flag && !status_clr);
    end
  end

  // live fault always blocks; latched flags block only with recovery disabled
  assign supply_block = sync_in[IN_OV] || sync_in[IN_UV] ||
                        (ctrl_word[BIT_REC_DIS] && (ov_flag || uv_flag));
  // warning flag deliberately absent here; enable_d darkens the cycle before not_ready rises
  assign outputs_ok = enable && enable_d && !not_ready &&
                      !tsd_flag && !supply_block;

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_outputs_enable     <= 1'b0;
      o_driver_on          <= DRV_OFF;
      o_standby            <= 1'b1;
      o_oc_retry_duty_high <= 1'b0;
    end else begin
      o_outputs_enable     <= outputs_ok;
      o_driver_on          <= outputs_ok ? ctrl_word[BIT_DRV_HI:BIT_DRV_LO] : DRV_OFF;
      o_standby            <= !enable;
      o_oc_retry_duty_high <= ctrl_word[BIT_OC_DUTY];
    end
  end

  // one-hot: [0] output_one, [1] output_four, [2] output_five, [3] output_eight
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_current_monitor_output <= 4'h8;
    end else begin
      case (ctrl_word[BIT_CM_HI:BIT_CM_LO])
        CM_OUTPUT_EIGHT: o_current_monitor_output <= 4'h8;
        CM_OUTPUT_ONE: o_current_monitor_output <= 4'h1;
        CM_OUTPUT_FIVE: o_current_monitor_output <= 4'h4;
        CM_OUTPUT_FOUR: o_current_monitor_output <= 4'h2;
        default: o_current_monitor_output <= 4'h8;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  logic [23:0] status_a;
  logic        fault;

  // built from the sources, not from status_a, so bit 0 never loops on itself
  assign fault    = ov_flag || uv_flag || tsd_flag || tw_flag || not_ready ||
                    (|i_overcurrent_flags) || (|i_status_word_b[22:1]);
  assign status_a = {1'b1, ov_flag, uv_flag, tsd_flag, tw_flag, not_ready,
                     i_overcurrent_flags, fault};

  // before the first clock the pin shows the fault bit alone
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      out_sr <= CTRL_RESET;
    end else if (cs_fall) begin
      out_sr <= {23'h000000, fault};
    end else if (state == SCS_FRAME && sck_rise && bit_cnt == 5'h00) begin
      out_sr <= di ? {i_status_word_b[23:1], fault} : status_a;
    end else if (state == SCS_FRAME && sck_fall && bit_cnt != 5'h00) begin
      out_sr <= {1'b0, out_sr[23:1]};
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_serial_output    <= 1'b0;
      o_serial_output_en <= 1'b0;
    end else begin
      o_serial_output    <= out_sr[0];
      o_serial_output_en <= !cs_low;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_rst_n);

  status_clear_a: assert property ((status_clr && !sync_in[IN_TSD]) |=> !tsd_flag)
    else $error("thermal flag not cleared by status clear");
  set_wins_a: assert property ((status_clr && sync_in[IN_OV]) |=> ov_flag)
    else $error("overvoltage event lost in clear cycle");
  duty_follow_a: assert property ((wr_a && in_sr[BIT_ENABLE]) |=>
                                   ##1 o_oc_retry_duty_high == $past(in_sr[BIT_OC_DUTY], 2))
    else $error("retry duty select not taken");
  supply_off_a: assert property (sync_in[IN_UV] |=> !o_outputs_enable)
    else $error("outputs on during supply fault");
  recovery_hold_a: assert property ((ctrl_word[BIT_REC_DIS] && (ov_flag || uv_flag))
                                    |=> !o_outputs_enable)
    else $error("auto resume with recovery disabled");
  msb_one_a: assert property ((state == SCS_FRAME && sck_rise && bit_cnt == 5'h00 && !di)
                              |=> out_sr[ST_ALWAYS_ONE])
    else $error("top status bit not one");
  thermal_off_a: assert property (tsd_flag |=> !o_outputs_enable)
    else $error("outputs on under thermal shutdown");
  warn_only_a: assert property ((tw_flag && enable && enable_d && !not_ready && !tsd_flag &&
                                 !supply_block) |=> o_outputs_enable)
    else $error("warning flag disabled outputs");
  not_ready_a: assert property ((enable && !enable_d) |=> not_ready [*2])
    else $error("not ready not held after activation");
  ready_gate_a: assert property ((enable && !enable_d) |=> !o_outputs_enable [*2])
    else $error("outputs on before charge pump settled");
  ready_end_a: assert property ($fell(not_ready) |-> enable)
    else $error("not ready dropped without expiry");
  monitor_sel_a: assert property ((ctrl_word[BIT_CM_HI:BIT_CM_LO] == CM_OUTPUT_FIVE)
                                  |=> o_current_monitor_output == 4'h4)
    else $error("monitor route wrong");
  standby_clr_a: assert property (go_standby |=> ctrl_word == CTRL_RESET ##1 o_standby)
    else $error("standby did not clear control word");
  exact_count_a: assert property ((ctrl_word != $past(ctrl_word))
                                  |-> $past(cs_rise && bit_cnt == FRAME_BITS))
    else $error("frame committed with wrong clock count");

  write_a_c: cover property (wr_a && in_sr[BIT_ENABLE]);
  write_b_c: cover property (wr_b);
  thermal_c: cover property (tsd_flag ##1 status_clr);
  ready_c: cover property ($fell(not_ready));
endmodule

/* File: verification/scs_host.sv */
// host-side serial master model driving the control/status link
module scs_host (
  input  wire logic i_sys_clk,
  input  wire logic i_so,
  input  wire logic i_so_en,
  output logic      o_sck,
  output logic      o_cs_n,
  output logic      o_di
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    o_sck = 1'b0;
    o_cs_n = 1'b1;
    o_di = 1'b0;
  end

  // idle data line keeps changing so a stale bit is never mistaken for data
  always @(posedge i_sys_clk) begin
    if (o_cs_n)
      o_di <= ~o_di;
  end

  ////////////////////////////////////////////////////////////////////////////
  // one frame of n clocks, lsb first; read bit sampled just before each rise
  task automatic frame(input logic [23:0] w, input int n, input int half,
                       output logic [23:0] rd);
    int i;
    rd = 24'h000000;
    @(posedge i_sys_clk) #1 o_cs_n = 1'b0;
    for (i = 0; i < n; i++) begin
      o_di = w[i % 24];
      repeat (half) @(posedge i_sys_clk);
      #1 if (i < 24) rd[i] = i_so_en ? i_so : 1'bx;
      o_sck = 1'b1;
      repeat (half) @(posedge i_sys_clk);
      #1 o_sck = 1'b0;
    end
    repeat (half) @(posedge i_sys_clk);
    #1 o_cs_n = 1'b1;
    // gap between frames also covers the commit latency
    repeat (8) @(posedge i_sys_clk);
  endtask
endmodule

/* File: verification/test_spi_control_status_upper_bits.sv */
// self-checking bench for the control/status upper-bit block
module test_spi_control_status_upper_bits;
  import scs_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [3:0]  cnd = 4'h0;
  logic [3:0]  flg = 4'h0;
  logic [16:0] oc = 17'h00000;
  logic [23:0] sb = 24'h000000;
  logic [23:0] ctrl = 24'h000000;
  logic [23:0] wordb = 24'h000000;
  logic [23:0] w;
  logic [3:0]  cm_map [4] = '{4'h8, 4'h1, 4'h4, 4'h2};
  logic [31:0] rng = 32'h00000014;
  logic [31:0] r;
  logic        sclr, wbw;
  int          n_clr = 0;
  int          n_wbw = 0;
  int          exp_clr = 0;
  int          exp_wbw = 0;
  logic        sck, cs_n, di, so, so_en, stby, oe, duty;
  logic [16:0] drv;
  logic [3:0]  cm;
  logic [23:0] wb;
  int          fail_count = 0;
  int          checked = 0;
  int          cycles = 0;
  int          k;

  always #10 clk = ~clk;

  scs_ctrl_status #(.P_STARTUP_CYCLES(20)) uut (
    .i_sys_clk(clk), .i_rst_n(rst_n), .i_serial_clock(sck),
    .i_chip_select_low(cs_n), .i_serial_input_pin(di),
    .i_load_supply_over(cnd[0]), .i_load_supply_under(cnd[1]),
    .i_thermal_shutdown(cnd[2]), .i_temperature_warning(cnd[3]),
    .i_overcurrent_flags(oc), .i_status_word_b(sb), .o_serial_output(so),
    .o_serial_output_en(so_en), .o_standby(stby), .o_outputs_enable(oe),
    .o_driver_on(drv), .o_oc_retry_duty_high(duty),
    .o_current_monitor_output(cm), .o_status_clear(sclr), .o_word_b(wb),
    .o_word_b_write(wbw)
  );

  scs_host host (
    .i_sys_clk(clk), .i_so(so), .i_so_en(so_en),
    .o_sck(sck), .o_cs_n(cs_n), .o_di(di)
  );

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction

  task automatic test_done();
    if (fail_count == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_out();
    logic en;
    en = ctrl[23] & ~flg[2] & ~cnd[0] & ~cnd[1] & ~(ctrl[20] & (flg[0] | flg[1]));
    chk("outputs_enable", {23'h0, en}, {23'h0, oe});
    chk("driver_on", {7'h0, en ? ctrl[17:1] : 17'h0}, {7'h0, drv});
    chk("standby", {23'h0, ~ctrl[23]}, {23'h0, stby});
    chk("monitor", {20'h0, cm_map[ctrl[19:18]]}, {20'h0, cm});
    chk("duty", {23'h0, ctrl[21]}, {23'h0, duty});
  endtask

  // frame through the host model, compared against the status model
  task automatic xfer(input logic [23:0] fw, input int n, input int half);
    logic [23:0] rd;
    logic [23:0] exp;
    exp = {1'b1, flg[0], flg[1], flg[2], flg[3], 1'b0, oc, 1'b0};
    exp[0] = (|exp[22:1]) | (|sb[22:1]);
    host.frame(fw, n, half, rd);
    // step off the edge so outputs are read settled
    #1;
    if (n == 24 && !fw[0])
      chk("read_a", exp, rd);
    if (n == 24 && fw[0])
      chk("read_b", {sb[23:1], exp[0]}, rd);
    if (n == 24 && !fw[0]) begin
      if (fw[22] || !fw[23]) begin
        flg = 4'h0;
        exp_clr++;
      end
      ctrl = fw[23] ? (fw & 24'hBFFFFE) : 24'h000000;
      if (!fw[23]) begin
        wordb = 24'h000000;
        exp_wbw++;
      end
    end
    if (n == 24 && fw[0]) begin
      wordb = fw;
      exp_wbw++;
    end
  endtask

  task automatic cond(input int idx, input logic v);
    @(posedge clk) #1 cnd[idx] = v;
    repeat (8) @(posedge clk);
    #1;
    if (v)
      flg[idx] = 1'b1;
  endtask

  // one-cycle pulses counted against the frames that should raise them
  always @(posedge clk) begin
    if (sclr === 1'b1)
      n_clr++;
    if (wbw === 1'b1)
      n_wbw++;
  end

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      fail_count++;
      test_done();
    end
  end

  initial begin
    repeat (12) @(posedge clk);
    #1 rst_n = 1'b1;
    repeat (4) @(posedge clk);
    #1;
    chk_out();
    xfer(24'h000000, 24, 8);
    for (k = 0; k < 4; k++) begin
      r = xs();
      w = {1'b1, 1'b0, k[0], 1'b0, k[1:0], r[16:0], 1'b0};
      xfer(w, 24, 8);
      if (k == 0) begin
        chk("not_ready_block", 24'h0, {22'h0, stby, oe});
        repeat (30) @(posedge clk);
        #1;
      end
      chk_out();
    end
    // standby content: a wrongly taken frame would show at once
    for (k = 23; k < 26; k += 2) begin
      r = xs();
      xfer({1'b0, r[21:0], 1'b0}, k, 8);
      chk_out();
    end
    cond(2, 1'b1);
    cond(2, 1'b0);
    chk_out();
    xfer(ctrl, 24, 8);
    chk_out();
    xfer(ctrl | 24'h400000, 24, 8);
    chk_out();
    cond(3, 1'b1);
    chk_out();
    cond(3, 1'b0);
    cond(0, 1'b1);
    chk_out();
    cond(0, 1'b0);
    chk_out();
    xfer(ctrl | 24'h400000, 24, 8);
    xfer(ctrl | 24'h100000, 24, 8);
    cond(1, 1'b1);
    cond(1, 1'b0);
    chk_out();
    xfer(ctrl | 24'h400000, 24, 8);
    chk_out();
    r = xs();
    oc = r[16:0];
    r = xs();
    sb = r[23:0];
    xfer(ctrl, 24, 8);
    r = xs();
    w = r[23:0] | 24'h000001;
    xfer(w, 24, 11);
    chk("word_b", wordb, wb);
    chk_out();
    oc = 17'h00000;
    sb = 24'h000000;
    xfer(24'h000000, 24, 8);
    chk_out();
    chk("word_b_clear", wordb, wb);
    chk("status_clear_count", 24'(exp_clr), 24'(n_clr));
    chk("word_b_write_count", 24'(exp_wbw), 24'(n_wbw));
    test_done();
  end
endmodule
